// ==== hw/mec_mac_eee_duplex.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mec_mac_eee_duplex #(
    parameter int WAIT_W = 16  // Width of the auto exit wait count
) (
    // Clock and resets
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        softReset,
    input  wire logic        resetProtect,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // GMII transmit side
    output logic             gtxClkRun,
    output logic             gmiiTxEr,
    output logic      [7:0]  gmiiTxd,
    // GMII receive side, PHY clock domain
    input  wire logic        rxClk,
    input  wire logic        rxDv,
    input  wire logic        rxEr,
    input  wire logic [7:0]  rxd,
    // PHY duplex indicator pin
    input  wire logic        phyFullDuplexLed,
    // Operating state
    output logic             fullDuplex
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                haltEn_reg;       // lowpower_txclk_halt_en
    logic                lpiEn_reg;        // lowpower_idle_en
    logic                autoExit_reg;     // lowpower_auto_exit_en
    logic                pol_reg;          // duplex_indicator_polarity
    logic                autoDpx_reg;      // Automatic duplex detection
    logic                dpx_reg;          // duplex_setting
    logic                txOn_reg;         // transmitter_on
    logic                rxOn_reg;         // receiver_on
    logic                spd100_reg;       // 100 Mb/s operation
    logic                lpiReq_reg;       // Software idle request
    logic [WAIT_W-1:0]   wait_reg;         // lowpower_auto_exit_wait
    logic [WAIT_W-1:0]   waitCnt_reg;      // Elapsed wait units
    logic [6:0]          usDiv_reg;        // Wait unit divider
    logic                usTick;           // One pulse per wait unit
    mec_pkg::mec_lpi_t   lpiState_reg;     // Transmit idle state
    mec_pkg::mec_lpi_t   lpiState_next;
    mec_pkg::mec_gmii_rx_t rxS1_reg, rxS2_reg, rxS3_reg;  // Pin synchroniser
    logic [2:0]          rxClkS_reg;       // Receive clock synchroniser
    logic                rxClkLvl_reg;     // Last agreed receive clock level
    logic                rxEdge;           // Receive clock rising edge
    logic                rxLpiSeen_reg;    // Idle indication decoded
    logic [2:0]          ledS_reg;         // Duplex pin synchroniser
    logic                ledLvl_reg;       // Last agreed duplex pin level
    logic                detected;         // Full duplex as indicated
    logic                acc;              // Access phase of a transfer
    logic                wrDone;           // Write takes effect
    logic                ctrlWr, waitWr, auxWr;
    logic [31:0]         rdMux;            // Read data before its flop
    logic                mapped;           // Address hits a register
    logic [11:0]         usCycles;

    assign usCycles = 12'(mec_pkg::US_CYC);

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: pready rises in the second access cycle
    assign acc    = psel && penable;
    assign wrDone = acc && pready && pwrite;
    assign mapped = paddr == mec_pkg::CTRL_OFS || paddr == mec_pkg::WAIT_OFS ||
                    paddr == mec_pkg::AUX_OFS;
    assign ctrlWr = wrDone && paddr == mec_pkg::CTRL_OFS;
    assign waitWr = wrDone && paddr == mec_pkg::WAIT_OFS;
    assign auxWr  = wrDone && paddr == mec_pkg::AUX_OFS;

    // Read data assembly, reserved bits read zero
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            mec_pkg::CTRL_OFS: begin
                rdMux[mec_pkg::HALT_BIT]    = haltEn_reg;
                rdMux[mec_pkg::LPIEN_BIT]   = lpiEn_reg;
                rdMux[mec_pkg::AUTOEX_BIT]  = autoExit_reg;
                rdMux[mec_pkg::POL_BIT]     = pol_reg;
                rdMux[mec_pkg::AUTODPX_BIT] = autoDpx_reg;
                rdMux[mec_pkg::DPX_BIT]     = dpx_reg;
            end
            mec_pkg::WAIT_OFS: rdMux[WAIT_W-1:0] = wait_reg;
            mec_pkg::AUX_OFS: begin
                rdMux[mec_pkg::TXON_BIT]    = txOn_reg;
                rdMux[mec_pkg::RXON_BIT]    = rxOn_reg;
                rdMux[mec_pkg::SPD100_BIT]  = spd100_reg;
                rdMux[mec_pkg::LPIREQ_BIT]  = lpiReq_reg;
                rdMux[mec_pkg::STLPI_BIT]   = lpiState_reg == mec_pkg::LPI_ON;
                rdMux[mec_pkg::STRXLPI_BIT] = rxLpiSeen_reg;
                rdMux[mec_pkg::STFDX_BIT]   = fullDuplex;
            end
            default: rdMux = 32'h0000_0000;  // Unmapped reads zero
        endcase
    end

    // Answer flops; unmapped addresses end with an error
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            prdata  <= (acc && !pready && !pwrite) ? rdMux : 32'h0000_0000;
            pslverr <= acc && !pready && !mapped;
        end
    end

    // ----------------------------------------
    // Protected control fields
    // ----------------------------------------
    // A protected reset leaves these alone while protection is on
    always_ff @(posedge mclk) begin
        if (reset || (softReset && !resetProtect)) begin
            haltEn_reg   <= mec_pkg::CTRL_RST;
            lpiEn_reg    <= mec_pkg::CTRL_RST;
            autoExit_reg <= mec_pkg::CTRL_RST;
            pol_reg      <= mec_pkg::POL_RST;
            autoDpx_reg  <= mec_pkg::CTRL_RST;
        end else if (ctrlWr) begin
            haltEn_reg   <= pwdata[mec_pkg::HALT_BIT];
            lpiEn_reg    <= pwdata[mec_pkg::LPIEN_BIT];
            autoExit_reg <= pwdata[mec_pkg::AUTOEX_BIT];
            pol_reg      <= pwdata[mec_pkg::POL_BIT];
            autoDpx_reg  <= pwdata[mec_pkg::AUTODPX_BIT];
        end
    end

    // ----------------------------------------
    // Unprotected fields
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset || softReset) begin
            txOn_reg   <= 1'b0;
            rxOn_reg   <= 1'b0;
            spd100_reg <= 1'b0;
            lpiReq_reg <= 1'b0;
            wait_reg   <= WAIT_W'(mec_pkg::WAIT_RST);
        end else begin
            if (auxWr) begin
                txOn_reg   <= pwdata[mec_pkg::TXON_BIT];
                rxOn_reg   <= pwdata[mec_pkg::RXON_BIT];
                spd100_reg <= pwdata[mec_pkg::SPD100_BIT];
                lpiReq_reg <= pwdata[mec_pkg::LPIREQ_BIT];
            end
            if (waitWr) begin
                wait_reg <= pwdata[WAIT_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Duplex detection
    // ----------------------------------------
    // Three-stage pin synchroniser; level counts once stages 2 and 3 agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            ledS_reg   <= 3'h0;
            ledLvl_reg <= 1'b0;
        end else begin
            ledS_reg <= {ledS_reg[1:0], phyFullDuplexLed};
            if (ledS_reg[1] == ledS_reg[2]) begin
                ledLvl_reg <= ledS_reg[2];
            end
        end
    end

    assign detected = ledLvl_reg == pol_reg;

    // Duplex bit: software value, or detected value in auto mode
    always_ff @(posedge mclk) begin
        if (reset || softReset) begin
            dpx_reg <= 1'b0;
        end else if (ctrlWr && !pwdata[mec_pkg::AUTODPX_BIT]) begin
            // Leaving auto mode: the written bit rules, not the last detection
            dpx_reg <= pwdata[mec_pkg::DPX_BIT];
        end else if (autoDpx_reg) begin
            dpx_reg <= detected;
        end else if (ctrlWr) begin
            dpx_reg <= pwdata[mec_pkg::DPX_BIT];
        end
    end

    // Operating duplex
    always_ff @(posedge mclk) begin
        if (reset) begin
            fullDuplex <= 1'b0;
        end else begin
            fullDuplex <= autoDpx_reg ? detected : dpx_reg;
        end
    end

    // ----------------------------------------
    // Receive low-power idle decode
    // ----------------------------------------
    // Clock and data share one synchroniser depth, so they stay aligned
    always_ff @(posedge mclk) begin
        if (reset) begin
            rxS1_reg     <= '0;
            rxS2_reg     <= '0;
            rxS3_reg     <= '0;
            rxClkS_reg   <= 3'h0;
            rxClkLvl_reg <= 1'b0;
        end else begin
            rxS1_reg   <= '{dv: rxDv, er: rxEr, d: rxd};
            rxS2_reg   <= rxS1_reg;
            rxS3_reg   <= rxS2_reg;
            rxClkS_reg <= {rxClkS_reg[1:0], rxClk};
            if (rxClkS_reg[1] == rxClkS_reg[2]) begin
                rxClkLvl_reg <= rxClkS_reg[2];
            end
        end
    end

    assign rxEdge = rxClkS_reg[1] && rxClkS_reg[2] && !rxClkLvl_reg;

    // Receiver enable is deliberately not consulted here
    always_ff @(posedge mclk) begin
        if (reset || !lpiEn_reg) begin
            rxLpiSeen_reg <= 1'b0;
        end else if (rxEdge) begin
            rxLpiSeen_reg <= !rxS3_reg.dv && rxS3_reg.er &&
                             rxS3_reg.d == mec_pkg::LPI_RXD;
        end
    end

    // ----------------------------------------
    // Transmit low-power idle
    // ----------------------------------------
    // Transmitter enable is deliberately not consulted here
    always_comb begin
        lpiState_next = lpiState_reg;
        unique case (lpiState_reg)
            mec_pkg::LPI_OFF: begin
                if (lpiEn_reg && lpiReq_reg) begin
                    lpiState_next = mec_pkg::LPI_ON;
                end
            end
            mec_pkg::LPI_ON: begin
                if (!lpiEn_reg || !lpiReq_reg) begin
                    lpiState_next = mec_pkg::LPI_OFF;
                end else if (autoExit_reg && waitCnt_reg >= wait_reg) begin
                    lpiState_next = mec_pkg::LPI_DONE;
                end
            end
            mec_pkg::LPI_DONE: begin
                // Stay out of idle until the request is withdrawn
                if (!lpiEn_reg || !lpiReq_reg) begin
                    lpiState_next = mec_pkg::LPI_OFF;
                end
            end
            default: lpiState_next = mec_pkg::LPI_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset || softReset) begin
            lpiState_reg <= mec_pkg::LPI_OFF;
        end else begin
            lpiState_reg <= lpiState_next;
        end
    end

    // Wait unit divider, restarted as idle signalling begins
    always_ff @(posedge mclk) begin
        if (reset || lpiState_reg != mec_pkg::LPI_ON) begin
            usDiv_reg <= 7'h00;
        end else if (usTick) begin
            usDiv_reg <= 7'h00;
        end else begin
            usDiv_reg <= usDiv_reg + 7'h01;
        end
    end

    assign usTick = 12'(usDiv_reg) == usCycles - 12'h001;

    // Elapsed wait, counted from entry to idle; saturates
    always_ff @(posedge mclk) begin
        if (reset || lpiState_reg != mec_pkg::LPI_ON) begin
            waitCnt_reg <= '0;
        end else if (usTick && waitCnt_reg != '1) begin
            waitCnt_reg <= waitCnt_reg + WAIT_W'(1);
        end
    end

    // Pin drive; clock halt only outside 100 Mb/s
    always_ff @(posedge mclk) begin
        if (reset) begin
            gmiiTxEr  <= 1'b0;
            gmiiTxd   <= 8'h00;
            gtxClkRun <= 1'b1;
        end else begin
            gmiiTxEr  <= lpiState_reg == mec_pkg::LPI_ON;
            gmiiTxd   <= (lpiState_reg == mec_pkg::LPI_ON) ? mec_pkg::LPI_TXD : 8'h00;
            gtxClkRun <= !(lpiState_reg == mec_pkg::LPI_ON && haltEn_reg
                           && !spd100_reg);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_halt_clock: assert property (
        lpiState_reg == mec_pkg::LPI_ON && haltEn_reg && !spd100_reg |=> !gtxClkRun)
        else $error("clock not halted in idle");
    a_halt_fast: assert property (spd100_reg |=> gtxClkRun)
        else $error("clock halted at 100 Mb/s");
    a_lpi_disable: assert property (
        !lpiEn_reg ##1 !lpiEn_reg |-> lpiState_reg == mec_pkg::LPI_OFF)
        else $error("idle active while disabled");
    a_lpi_notx: assert property (!softReset && lpiEn_reg && lpiReq_reg
        && lpiState_reg == mec_pkg::LPI_OFF |=> gmiiTxEr == 1'b0 ##1 gmiiTxEr)
        else $error("idle request not issued");
    a_rx_decode: assert property (rxEdge && lpiEn_reg && !rxS3_reg.dv && rxS3_reg.er
        && rxS3_reg.d == mec_pkg::LPI_RXD ##1 lpiEn_reg |-> rxLpiSeen_reg)
        else $error("idle indication missed");
    a_auto_exit: assert property (!softReset && lpiState_reg == mec_pkg::LPI_ON
        && autoExit_reg && lpiEn_reg && lpiReq_reg && waitCnt_reg >= wait_reg
        |=> lpiState_reg == mec_pkg::LPI_DONE)
        else $error("auto exit late");
    a_wait_start: assert property (lpiState_reg == mec_pkg::LPI_OFF ##1
        lpiState_reg == mec_pkg::LPI_ON |-> waitCnt_reg == '0 && usDiv_reg == 7'h00)
        else $error("wait did not start at entry");
    a_dpx_auto: assert property (
        autoDpx_reg ##1 autoDpx_reg |=> fullDuplex == $past(detected))
        else $error("auto duplex wrong");
    a_dpx_read: assert property (
        autoDpx_reg && !softReset && !(ctrlWr && !pwdata[mec_pkg::AUTODPX_BIT])
        |=> dpx_reg == $past(detected))
        else $error("duplex bit not reflected");
    a_dpx_manual: assert property (!autoDpx_reg |=> fullDuplex == $past(dpx_reg))
        else $error("manual duplex wrong");
    a_protect_keep: assert property (softReset && resetProtect && !ctrlWr
        |=> $stable(pol_reg) && $stable(lpiEn_reg) && $stable(haltEn_reg))
        else $error("protected field lost");

    c_lpi_enter: cover property (
        lpiState_reg == mec_pkg::LPI_OFF ##1 lpiState_reg == mec_pkg::LPI_ON);
    c_auto_exit: cover property (
        lpiState_reg == mec_pkg::LPI_ON ##1 lpiState_reg == mec_pkg::LPI_DONE);
    c_clk_halt: cover property (!gtxClkRun);
    c_protect: cover property (softReset && resetProtect);
endmodule
`default_nettype wire

// ==== pkg/mec_pkg.sv ====
`default_nettype none
package mec_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h100;  // mac_operating_control
    localparam logic [11:0] WAIT_OFS = 12'h104;  // lowpower_auto_exit_wait
    localparam logic [11:0] AUX_OFS  = 12'h108;  // Link side controls and status

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int HALT_BIT    = 18;  // lowpower_txclk_halt_en
    localparam int LPIEN_BIT   = 17;  // lowpower_idle_en
    localparam int AUTOEX_BIT  = 16;  // lowpower_auto_exit_en
    localparam int POL_BIT     = 13;  // duplex_indicator_polarity
    localparam int AUTODPX_BIT = 12;  // Automatic duplex detection
    localparam int DPX_BIT     = 3;   // duplex_setting
    localparam int TXON_BIT    = 0;   // transmitter_on
    localparam int RXON_BIT    = 1;   // receiver_on
    localparam int SPD100_BIT  = 2;   // Link runs at 100 Mb/s
    localparam int LPIREQ_BIT  = 3;   // Software asks for transmit low-power idle
    localparam int STLPI_BIT   = 8;   // Transmit low-power idle active
    localparam int STRXLPI_BIT = 9;   // Receive low-power idle seen
    localparam int STFDX_BIT   = 10;  // Operating duplex, 1 = full

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic POL_RST   = 1'b1;
    localparam logic CTRL_RST  = 1'b0;  // All other control bits
    localparam logic [15:0] WAIT_RST = 16'h0000;

    // ----------------------------------------
    // Line codes and timing
    // ----------------------------------------
    localparam logic [7:0] LPI_TXD = 8'h01;  // Assert low-power idle code
    localparam logic [7:0] LPI_RXD = 8'h01;  // Low-power idle indication code
    localparam int US_NS  = 1000;            // Wait unit, in ns
    localparam int CLK_NS = 8;               // mclk period, in ns
    localparam int US_CYC = US_NS / CLK_NS;  // Cycles per wait unit

    // Transmit low-power idle states, Gray coded
    typedef enum logic [1:0] {
        LPI_OFF  = 2'b00,
        LPI_ON   = 2'b01,
        LPI_DONE = 2'b11
    } mec_lpi_t;

    // Receive pins bundle
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [7:0] d;
    } mec_gmii_rx_t;
endpackage
`default_nettype wire

// ==== test/mec_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mec_phy_model (
    // Commands from the bench
    input  wire logic                  clkOn,
    input  wire logic                  lpiCmd,
    input  wire logic                  fdxCmd,
    // Pins toward the MAC
    output logic                       rxClk,
    output var mec_pkg::mec_gmii_rx_t  rxBus,
    output logic                       phyFullDuplexLed,
    output logic                       stopCapable
);
    // ----------------------------------------
    // Status pins
    // ----------------------------------------
    // Management bit: a halted transmit clock is tolerated
    assign stopCapable = 1'b1;
    // Duplex indicator, active high
    assign phyFullDuplexLed = fdxCmd;

    // ----------------------------------------
    // Receive clock and data
    // ----------------------------------------
    // Clock stands still between active periods; data changes after the fall
    initial begin
        rxClk = 1'b0;
        rxBus = 10'h000;
        #5;
        forever begin
            #32;
            if (clkOn) begin
                rxClk = ~rxClk;
                if (!rxClk) begin
                    rxBus.dv = 1'b0;
                    rxBus.er = lpiCmd;
                    rxBus.d  = lpiCmd ? mec_pkg::LPI_RXD : 8'h00;
                end
            end else begin
                rxClk   = 1'b0;
                // Stale data wanders so it is never read as live
                rxBus.d = ~rxBus.d;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/mac_eee_duplex_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mac_eee_duplex_control_test;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic                  mclk, reset, softReset, resetProtect;
    logic                  psel, penable, pwrite, pready, pslverr, rdErr;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rdData;
    logic                  gtxClkRun, gmiiTxEr, fullDuplex, rxClk;
    logic                  phyFullDuplexLed, stopCapable, clkOn, lpiCmd, fdxCmd;
    logic [7:0]            gmiiTxd;
    mec_pkg::mec_gmii_rx_t rxBus;
    int                    error_cnt, checks_done, n;
    // Field masks
    localparam logic [31:0] HALT = 32'h1 << mec_pkg::HALT_BIT;
    localparam logic [31:0] LPIEN = 32'h1 << mec_pkg::LPIEN_BIT;
    localparam logic [31:0] AUTOEX = 32'h1 << mec_pkg::AUTOEX_BIT;
    localparam logic [31:0] POL = 32'h1 << mec_pkg::POL_BIT;
    localparam logic [31:0] ADPX = 32'h1 << mec_pkg::AUTODPX_BIT;
    localparam logic [31:0] DUPLEX_SETTING = 32'h1 << mec_pkg::DPX_BIT;
    localparam logic [31:0] KEEP = HALT | LPIEN | AUTOEX | POL | ADPX;  // Protected fields

    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    mec_mac_eee_duplex dut_u (.mclk(mclk), .reset(reset), .softReset(softReset),
        .resetProtect(resetProtect), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gtxClkRun(gtxClkRun), .gmiiTxEr(gmiiTxEr), .gmiiTxd(gmiiTxd), .rxClk(rxClk),
        .rxDv(rxBus.dv), .rxEr(rxBus.er), .rxd(rxBus.d), .phyFullDuplexLed(phyFullDuplexLed),
        .fullDuplex(fullDuplex));
    mec_phy_model phy_u (.clkOn(clkOn), .lpiCmd(lpiCmd), .fdxCmd(fdxCmd), .rxClk(rxClk),
        .rxBus(rxBus), .phyFullDuplexLed(phyFullDuplexLed), .stopCapable(stopCapable));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdData);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    // Transmit pins as {clock run, error, data}
    function automatic logic [31:0] pins();
        return {22'h0, gtxClkRun, gmiiTxEr, gmiiTxd};
    endfunction

    // ----------------------------------------
    // Clock and test sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {error_cnt, checks_done, n} = 0;
        {reset, softReset, resetProtect} = 3'h4;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        {clkOn, lpiCmd, fdxCmd} = 3'h0;
        cyc(20);
        reset <= 1'b0;
        // Reset values, unmapped place
        rdChk("ctrl reset", mec_pkg::CTRL_OFS, POL);
        rdChk("wait reset", mec_pkg::WAIT_OFS, 32'h0);
        rdChk("unmapped data", 12'h1FC, 32'h0);
        chk("unmapped err", 32'h1, rdErr);
        // Duplex detection, both polarities, then manual
        fdxCmd <= 1'b1;
        wr(mec_pkg::CTRL_OFS, POL | ADPX);
        cyc(10);
        chk("auto full", 32'h1, fullDuplex);
        rdChk("dpx reflect", mec_pkg::CTRL_OFS, POL | ADPX | DUPLEX_SETTING);
        fdxCmd <= 1'b0;
        cyc(10);
        chk("auto half", 32'h0, fullDuplex);
        wr(mec_pkg::CTRL_OFS, ADPX);
        cyc(10);
        chk("low polarity", 32'h1, fullDuplex);
        // Detection now says half, so the manual write must win on its own
        fdxCmd <= 1'b1;
        cyc(10);
        chk("low pol half", 32'h0, fullDuplex);
        wr(mec_pkg::CTRL_OFS, DUPLEX_SETTING);
        cyc(4);
        chk("manual full", 32'h1, fullDuplex);
        wr(mec_pkg::CTRL_OFS, 32'h0);
        cyc(10);
        chk("manual half", 32'h0, fullDuplex);
        // Transmit idle with clock halt, transmitter left off
        if (stopCapable === 1'b1) wr(mec_pkg::CTRL_OFS, HALT | LPIEN);
        wr(mec_pkg::AUX_OFS, 32'h8);
        cyc(3);
        chk("idle pins", 32'h101, pins());
        rdChk("idle status", mec_pkg::AUX_OFS, 32'h108);
        wr(mec_pkg::AUX_OFS, 32'hC);
        cyc(3);
        chk("halt at 100M", 32'h301, pins());
        wr(mec_pkg::AUX_OFS, 32'h4);
        cyc(3);
        chk("idle exit", 32'h200, pins());
        wr(mec_pkg::CTRL_OFS, HALT);
        wr(mec_pkg::AUX_OFS, 32'h8);
        cyc(3);
        chk("idle disabled", 32'h200, pins());
        // Automatic exit after two wait units
        wr(mec_pkg::CTRL_OFS, AUTOEX);
        wr(mec_pkg::WAIT_OFS, 32'h2);
        wr(mec_pkg::CTRL_OFS, LPIEN | AUTOEX);
        while (gmiiTxEr !== 1'b1 && n < 10) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        while (gmiiTxEr === 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk("auto exit span", 32'h1, n >= 248 && n <= 252);
        cyc(20);
        chk("stays out", 32'h0, gmiiTxEr);
        wr(mec_pkg::AUX_OFS, 32'h0);
        wr(mec_pkg::CTRL_OFS, AUTOEX);
        // Receive idle with receiver off, then with idle disabled
        wr(mec_pkg::CTRL_OFS, LPIEN);
        clkOn  <= 1'b1;
        lpiCmd <= 1'b1;
        cyc(40);
        rdChk("rx idle seen", mec_pkg::AUX_OFS, 32'h200);
        lpiCmd <= 1'b0;
        cyc(40);
        rdChk("rx idle gone", mec_pkg::AUX_OFS, 32'h0);
        wr(mec_pkg::CTRL_OFS, 32'h0);
        lpiCmd <= 1'b1;
        cyc(40);
        rdChk("rx ignored", mec_pkg::AUX_OFS, 32'h0);
        clkOn <= 1'b0;
        // Protected and unprotected soft reset
        wr(mec_pkg::CTRL_OFS, POL | ADPX | AUTOEX);
        wr(mec_pkg::CTRL_OFS, KEEP);
        {resetProtect, softReset} <= 2'h3;
        cyc(2);
        softReset <= 1'b0;
        cyc(10);
        rdChk("kept ctrl", mec_pkg::CTRL_OFS, KEEP | DUPLEX_SETTING);
        {resetProtect, softReset} <= 2'h1;
        cyc(2);
        softReset <= 1'b0;
        cyc(2);
        rdChk("cleared ctrl", mec_pkg::CTRL_OFS, POL);
        stop_test();
    end
endmodule
`default_nettype wire
